// ===== verilog/dhsp_pkg.sv
package dhsp_pkg;
   // Frame lengths of the primary and secondary ports
   localparam int unsigned PRI_SHORT_BITS = 16;
   localparam int unsigned PRI_LONG_BITS  = 32;
   localparam int unsigned SEC_BITS       = 16;
   localparam int unsigned REG_COUNT      = 87;
   localparam int unsigned ADDR_W         = 7;
   localparam int unsigned SEC_REG_COUNT  = 8;
   // Bits of a read header after which the addressed word is loaded
   localparam int unsigned READ_BITS      = 8;
   // Switch command register address and bit
   localparam logic [6:0]  SWITCH_ADDR    = 7'h56;
   localparam int unsigned SWITCH_BIT     = 0;
   localparam logic [15:0] REG_RESET      = 16'h0000;
   // Logic clock and switch delay
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned SWITCH_DELAY_NS = 5000;
   localparam int unsigned SWITCH_CYCLES   =
      (SWITCH_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Longest switch delay allowed, 10 us of logic clock
   localparam int unsigned MAX_DELAY_CYCLES = 10 * (CLK_HZ / 1_000_000);

   typedef struct packed {
      logic sel_n;
      logic sck;
      logic din;
   } dhsp_pins_s;
endpackage

// ===== verilog/dhsp_ports.sv
`timescale 1ns/10ps
module dhsp_ports #(
   parameter int unsigned DELAY_CYCLES = dhsp_pkg::SWITCH_CYCLES
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              nrst,
   // Primary host port
   input  wire dhsp_pkg::dhsp_pins_s pri_pins,
   output logic                   pri_miso,
   output logic                   pri_miso_oe_n,
   // Secondary readout port
   input  wire logic              sec_sel_n,
   input  wire logic              sec_sck,
   output logic                   sec_miso,
   output logic                   sec_miso_oe_n,
   // Auxiliary switch
   output logic                   aux_switch_closed
);
   import dhsp_pkg::*;

   initial begin
      if (DELAY_CYCLES < 1 || DELAY_CYCLES > MAX_DELAY_CYCLES)
         $error("DELAY_CYCLES out of range");
   end

   // Two-stage synchronisers
   logic [2:0] pri_s1, pri_s2, pri_d;
   logic [1:0] sec_s1, sec_s2, sec_d;
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         pri_s1 <= 3'h7;
         pri_s2 <= 3'h7;
         pri_d  <= 3'h7;
         sec_s1 <= 2'h3;
         sec_s2 <= 2'h3;
         sec_d  <= 2'h3;
      end else begin
         pri_s1 <= {pri_pins.sel_n, pri_pins.sck, pri_pins.din};
         pri_s2 <= pri_s1;
         pri_d  <= pri_s2;
         sec_s1 <= {sec_sel_n, sec_sck};
         sec_s2 <= sec_s1;
         sec_d  <= sec_s2;
      end
   end

   wire p_sel_n = pri_s2[2];
   wire p_rise  = pri_s2[1] & ~pri_d[1] & ~p_sel_n;
   wire p_fall  = ~pri_s2[1] & pri_d[1] & ~p_sel_n;
   wire p_done  = p_sel_n & ~pri_d[2];
   wire p_start = ~p_sel_n & pri_d[2];
   wire s_sel_n = sec_s2[1];
   wire s_fall  = ~sec_s2[0] & sec_d[0] & ~s_sel_n;
   wire s_start = ~s_sel_n & sec_d[1];

   // Register file
   logic [15:0] regs [REG_COUNT];
   logic [31:0] p_shift;
   logic [5:0]  p_count;
   logic [31:0] p_out;
   logic [15:0] s_out;
   logic [2:0]  s_ptr;

   // Frame: bit 15 write, [14:8] address, [7:0] low data byte; long frame ignores [7:0] and adds the whole 16-bit word
   wire         is_short = (p_count == 6'(PRI_SHORT_BITS));
   wire         is_long  = (p_count == 6'(PRI_LONG_BITS));
   wire [15:0]  hdr      = is_long ? p_shift[31:16] : p_shift[15:0];
   wire         wr       = hdr[15];
   wire [6:0]   addr     = hdr[14:8];
   wire [15:0]  wdata    = is_long ? p_shift[15:0] : {8'h00, hdr[7:0]};
   wire         addr_ok  = addr < 7'(REG_COUNT);
   wire         commit   = p_done & (is_short | is_long) & wr & addr_ok;
   // After the first byte the address sits in the low seven shifted bits
   wire [6:0]   rd_addr  = p_shift[6:0];
   wire [15:0]  rd_word  = (rd_addr < 7'(REG_COUNT)) ? regs[rd_addr] : 16'h0000;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < REG_COUNT; i++)
            regs[i] <= REG_RESET;
      end else if (commit) begin
         regs[addr] <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         p_shift <= 32'h0;
         p_count <= 6'h0;
      end else if (p_start) begin
         p_count <= 6'h0;
      end else if (p_rise) begin
         p_shift <= {p_shift[30:0], pri_s2[0]};
         if (p_count != 6'h3f)
            p_count <= p_count + 6'h1;
      end
   end

   // Primary output: one pad bit after the header byte, then the word MSB first
   wire         p_load        = (p_count == 6'(READ_BITS));
   wire [31:0]  next_p_out    = p_load ? {rd_word, 16'h0000} : {p_out[30:0], 1'b0};
   wire         next_pri_miso = p_load ? 1'b0 : p_out[31];
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         p_out    <= 32'h0;
         pri_miso <= 1'b0;
      end else if (p_start) begin
         p_out    <= 32'h0;
         pri_miso <= 1'b0;
      end else if (p_fall) begin
         p_out    <= next_p_out;
         pri_miso <= next_pri_miso;
      end
   end
   assign pri_miso_oe_n = p_sel_n;

   // Secondary port reads the last eight registers in turn
   function automatic int unsigned sec_index(input logic [2:0] ptr);
      return REG_COUNT - SEC_REG_COUNT + 32'(ptr);
   endfunction
   wire [15:0]  s_word = regs[sec_index(s_ptr)];
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         s_out    <= 16'h0;
         s_ptr    <= 3'h0;
         sec_miso <= 1'b0;
      end else if (s_start) begin
         s_out    <= s_word;
         s_ptr    <= s_ptr + 3'h1;
         sec_miso <= s_word[SEC_BITS-1];
      end else if (s_fall) begin
         s_out    <= {s_out[14:0], 1'b0};
         sec_miso <= s_out[14];
      end
   end
   assign sec_miso_oe_n = s_sel_n;

   // Switch follows its command bit after the delay count
   logic [10:0] sw_cnt;
   wire         sw_cmd = regs[SWITCH_ADDR][SWITCH_BIT];
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sw_cnt            <= 11'h0;
         aux_switch_closed <= 1'b0;
      end else if (sw_cmd == aux_switch_closed) begin
         sw_cnt <= 11'h0;
      end else if (sw_cnt >= 11'(DELAY_CYCLES - 1)) begin
         aux_switch_closed <= sw_cmd;
         sw_cnt            <= 11'h0;
      end else begin
         sw_cnt <= sw_cnt + 11'h1;
      end
   end
endmodule

// ===== testbench/dhsp_ports_checker.sv
`timescale 1ns/10ps
module dhsp_ports_checker #(parameter int unsigned DELAY_CYCLES = 4) (
   input wire logic core_clk, nrst, pri_miso, pri_miso_oe_n, sec_sel_n, sec_sck,
   input wire logic sec_miso, sec_miso_oe_n, aux_switch_closed,
   input wire dhsp_pkg::dhsp_pins_s pri_pins
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_ra; disable iff (1'b0) !nrst |=> !aux_switch_closed && pri_miso_oe_n; endproperty
   a_ra: assert property (p_ra) else $error("reset state");
   property p_po; pri_pins.sel_n [*4] |-> pri_miso_oe_n; endproperty
   a_po: assert property (p_po) else $error("pri released");
   property p_pd; !pri_pins.sel_n [*4] |-> !pri_miso_oe_n; endproperty
   a_pd: assert property (p_pd) else $error("pri driven");
   property p_so; sec_sel_n [*4] |-> sec_miso_oe_n; endproperty
   a_so: assert property (p_so) else $error("sec released");
   property p_ph; (!pri_pins.sel_n && pri_pins.sck) [*6] |-> $stable(pri_miso); endproperty
   a_ph: assert property (p_ph) else $error("pri out moved");
   property p_sh; (!sec_sel_n && sec_sck) [*6] |-> $stable(sec_miso); endproperty
   a_sh: assert property (p_sh) else $error("sec out moved");
   property p_sw; $changed(aux_switch_closed) |-> $past(pri_pins.sel_n, DELAY_CYCLES); endproperty
   a_sw: assert property (p_sw) else $error("switch early");
   property p_sf; !pri_pins.sel_n [*8] |-> $stable(aux_switch_closed); endproperty
   a_sf: assert property (p_sf) else $error("switch in frame");
   c_on: cover property ($rose(aux_switch_closed));
   c_off: cover property ($fell(aux_switch_closed));
   c_sec: cover property (!sec_miso_oe_n);
endmodule
bind dhsp_ports dhsp_ports_checker #(.DELAY_CYCLES(DELAY_CYCLES)) u_chk (.*);

// ===== testbench/dhsp_host_model.sv
`timescale 1ns/10ps
module dhsp_host_model (
   output dhsp_pkg::dhsp_pins_s pri,
   output logic                 sec_sel_n, sec_sck,
   input  wire logic            pri_miso,
   input  wire logic            sec_miso
);
   initial {pri, sec_sel_n, sec_sck} = 5'h12;
   // Data changes while the serial clock is low; data out is taken at each rise
   task automatic pri_xfer(input logic [31:0] w, input int n, output logic [31:0] r);
      r = 32'h0;
      pri.sel_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         pri.din <= w[i];
         #62.5 pri.sck <= 1'b1;
         r[i] = pri_miso;
         #62.5 pri.sck <= 1'b0;
      end
      #62.5 pri.sel_n <= 1'b1;
      pri.din <= ~pri.din;
      #300;
   endtask
   task automatic sec_read(output logic [15:0] w);
      sec_sel_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         #62.5 sec_sck <= 1'b1;
         w[i] = sec_miso;
         #62.5 sec_sck <= 1'b0;
      end
      #62.5 sec_sel_n <= 1'b1;
      #300;
   endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
module tb;
   import dhsp_pkg::*;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        sw, poe, soe, smiso, ssel_n, ssck, pmiso;
   logic [15:0] rd;
   logic [31:0] pr;
   dhsp_pins_s  pins;
   int          miscompares = 0;
   int          checks_done = 0;
   always #4 core_clk = ~core_clk;
   dhsp_host_model u_host (.pri(pins), .sec_sel_n(ssel_n), .sec_sck(ssck),
      .pri_miso(pmiso), .sec_miso(smiso));
   dhsp_ports #(.DELAY_CYCLES(4)) u_dut (.core_clk(core_clk), .nrst(nrst), .pri_pins(pins),
      .pri_miso(pmiso), .pri_miso_oe_n(poe), .sec_sel_n(ssel_n), .sec_sck(ssck),
      .sec_miso(smiso), .sec_miso_oe_n(soe), .aux_switch_closed(sw));
   task automatic cmp(string nm, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wait_sw(logic exp);
      for (int i = 0; i < 80 && sw !== exp; i++) @(posedge core_clk);
      cmp("switch", {15'h0, exp}, {15'h0, sw});
   endtask
   task automatic t_reset;
      cmp("oe", 16'h0003, {14'h0, poe, soe});
      wait_sw(1'b0);
   endtask
   task automatic t_switch;
      u_host.pri_xfer(32'h0000d601, 16, pr);
      wait_sw(1'b1);
      u_host.pri_xfer(32'h00d60000, 24, pr);
      wait_sw(1'b1);
      u_host.pri_xfer(32'h00005600, 16, pr);
      wait_sw(1'b1);
      u_host.pri_xfer(32'hd6000000, 32, pr);
      wait_sw(1'b0);
   endtask
   // Write register 79 long, then read it back: pad bit, then word on bits 22..7
   task automatic t_pri_read;
      u_host.pri_xfer(32'hcf00a5c3, 32, pr);
      u_host.pri_xfer(32'h4f000000, 32, pr);
      cmp("pri word", 16'ha5c3, pr[22:7]);
   endtask
   task automatic t_sec;
      for (int k = 0; k < 8; k++) begin
         u_host.sec_read(rd);
         cmp("sec word", (k == 0) ? 16'ha5c3 : REG_RESET, rd);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      t_reset();
      nrst <= 1'b1;
      repeat (4) @(posedge core_clk);
      t_switch();
      t_pri_read();
      t_sec();
      finish_test();
   end
endmodule
